// file: hw/dxm_ext_mem.sv
// dual external memory port: program and data memory bus engines
// assumes float pins idle high and ack idles low, one core clock, no registers
`timescale 1ns/100ps
`default_nettype none

// one bus engine, used once per memory port
module dxm_port_engine
  import dxm_pkg::*;
#(
  parameter int AW  = 24,
  parameter int DW  = 48,
  parameter int NB  = 2,
  parameter int NSH = 16
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     req_write,
  input  wire logic                     req_narrow,
  input  wire logic [AW-1:0]            req_addr,
  input  wire logic [DW-1:0]            req_wdata,
  output logic                          rsp_valid,
  output logic      [DW-1:0]            rsp_rdata,
  output logic                          busy,
  input  wire logic [NB-2:0][AW-1:0]    bank_start,
  input  wire logic [NB-1:0][WAIT_W-1:0] bank_waits,
  input  wire logic [SHIFT_W-1:0]       page_shift,
  output logic      [AW-1:0]            addr_o,
  output logic      [DW-1:0]            data_o,
  output logic                          data_oe,
  input  wire logic [DW-1:0]            data_s,
  output logic      [NB-1:0]            bank_sel_n,
  output logic                          rd_strobe,
  output logic                          wr_strobe,
  output logic                          bus_oe,
  output logic                          page_cross,
  input  wire logic                     ack_s,
  input  wire logic                     float_s
);

  localparam int BW = $clog2(NB);

  dxm_state_e          state_r;
  logic [WAIT_W-1:0]   wait_r;
  logic [AW-1:0]       last_page_r;
  logic                page_valid_r;
  logic                narrow_r;
  logic [BW-1:0]       req_bank;
  logic [AW-1:0]       req_page;
  logic                accept;
  logic                done;

  // bank index = number of bank start boundaries at or below the address
  function automatic logic [BW-1:0] bank_of(input logic [AW-1:0] a,
      input logic [NB-2:0][AW-1:0] starts);
    logic [BW-1:0] n;
    n = '0;
    for (int i = 0; i < NB - 1; i++) begin
      if (a >= starts[i]) begin
        n = BW'(i + 1);
      end
    end
    return n;
  endfunction

  // page number under the configured page size
  function automatic logic [AW-1:0] page_of(input logic [AW-1:0] a,
      input logic [SHIFT_W-1:0] sh);
    return a >> sh;
  endfunction

  function automatic logic [NB-1:0] sel_of(input logic [BW-1:0] b);
    logic [NB-1:0] s;
    s = '1;
    s[b] = 1'b0;
    return s;
  endfunction

  assign req_bank  = bank_of(req_addr, bank_start);
  assign req_page  = page_of(req_addr, page_shift);
  // no new access while the bus is floated by the far side
  assign accept    = (state_r == DXM_IDLE) && req_valid && !float_s;
  assign req_ready = accept;
  // access ends only with waits spent and acknowledge seen
  assign done      = (state_r == DXM_ACC) && !float_s &&
                     (wait_r == '0) && ack_s;
  assign busy      = (state_r != DXM_IDLE);

  // outputs float whenever the far side asks for the bus
  assign bus_oe  = !float_s;
  assign data_oe = !float_s && wr_strobe;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DXM_IDLE;
    end else begin
      unique case (state_r)
        DXM_IDLE: begin
          if (accept) begin
            state_r <= DXM_ACC;
          end
        end
        DXM_ACC: begin
          if (float_s) begin
            state_r <= DXM_HALT;
          end else if (done) begin
            state_r <= DXM_IDLE;
          end
        end
        DXM_HALT: begin
          // resumes, then needs acknowledge before it can finish
          if (!float_s) begin
            state_r <= DXM_ACC;
          end
        end
        default: begin
          state_r <= DXM_IDLE;
        end
      endcase
    end
  end

  // address and selects follow the request while idle, so the select
  // shows in the same cycle as the strobe unless a float holds off accept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_o     <= '0;
      bank_sel_n <= '1;
    end else if (state_r == DXM_IDLE) begin
      if (req_valid) begin
        addr_o     <= req_addr;
        bank_sel_n <= sel_of(req_bank);
      end else begin
        bank_sel_n <= '1;
      end
    end else if (done) begin
      bank_sel_n <= '1;
    end
  end

  // strobes come from one write flag, so they can never overlap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
    end else if (accept) begin
      rd_strobe <= !req_write;
      wr_strobe <= req_write;
    end else if (done) begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
    end
  end

  // wait counter freezes while halted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= '0;
    end else if (accept) begin
      wait_r <= bank_waits[req_bank];
    end else if (state_r == DXM_ACC && !float_s && wait_r != '0) begin
      wait_r <= wait_r - WAIT_W'(1);
    end
  end

  // write data; narrow values sit in the upper bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_o   <= '0;
      narrow_r <= 1'b0;
    end else if (accept) begin
      narrow_r <= req_narrow;
      if (req_narrow) begin
        data_o <= {req_wdata[NARROW_W-1:0], NSH'(0)};
      end else begin
        data_o <= req_wdata;
      end
    end
  end

  // read data captured on the completing cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= done;
      if (done && rd_strobe) begin
        if (narrow_r) begin
          rsp_rdata <= DW'(data_s[DW-1:NSH]);
        end else begin
          rsp_rdata <= data_s;
        end
      end
    end
  end

  // page flag stands for the whole access that entered a new page;
  // the first access after reset counts as a crossing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      page_cross   <= 1'b0;
      last_page_r  <= '0;
      page_valid_r <= 1'b0;
    end else if (accept) begin
      page_cross   <= !page_valid_r || (req_page != last_page_r);
      last_page_r  <= req_page;
      page_valid_r <= 1'b1;
    end else if (done) begin
      page_cross <= 1'b0;
    end
  end

endmodule

module dxm_ext_mem
  import dxm_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // core side, program memory
  input  wire logic                  prog_req_valid,
  output logic                       prog_req_ready,
  input  wire logic                  prog_req_write,
  input  wire logic                  prog_req_narrow,
  input  wire logic [PROG_AW-1:0]    prog_req_addr,
  input  wire logic [PROG_DW-1:0]    prog_req_wdata,
  output logic                       prog_rsp_valid,
  output logic      [PROG_DW-1:0]    prog_rsp_rdata,
  output logic                       prog_busy,
  input  wire dxm_prog_cfg_s         prog_cfg,
  // core side, data memory
  input  wire logic                  data_req_valid,
  output logic                       data_req_ready,
  input  wire logic                  data_req_write,
  input  wire logic                  data_req_narrow,
  input  wire logic [DATA_AW-1:0]    data_req_addr,
  input  wire logic [DATA_DW-1:0]    data_req_wdata,
  output logic                       data_rsp_valid,
  output logic      [DATA_DW-1:0]    data_rsp_rdata,
  output logic                       data_busy,
  input  wire dxm_data_cfg_s         data_cfg,
  // program memory pins
  output logic      [PROG_AW-1:0]    prog_addr,
  output logic                       prog_addr_oe,
  input  wire logic [PROG_DW-1:0]    prog_data_i,
  output logic      [PROG_DW-1:0]    prog_data_o,
  output logic                       prog_data_oe,
  output logic      [PROG_NB-1:0]    prog_bank_sel_n,
  output logic                       prog_bank_sel_oe,
  output logic                       prog_rd_strobe_n,
  output logic                       prog_wr_strobe_n,
  output logic                       prog_strobe_oe,
  output logic                       prog_page_cross,
  input  wire logic                  prog_ack,
  input  wire logic                  prog_float_req_n,
  // data memory pins
  output logic      [DATA_AW-1:0]    data_addr,
  output logic                       data_addr_oe,
  input  wire logic [DATA_DW-1:0]    data_bus_i,
  output logic      [DATA_DW-1:0]    data_bus_o,
  output logic                       data_bus_oe,
  output logic      [DATA_NB-1:0]    data_bank_sel_n,
  output logic                       data_bank_sel_oe,
  output logic                       data_rd_strobe_n,
  output logic                       data_wr_strobe_n,
  output logic                       data_strobe_oe,
  output logic                       data_page_cross,
  input  wire logic                  data_ack,
  input  wire logic                  data_float_req_n
);

  localparam int PSW = PROG_DW + 2;
  localparam int DSW = DATA_DW + 2;

  logic [SYNC_DEPTH-1:0] rst_sync_r;
  logic                  rst_n;
  logic [PSW-1:0]        prog_s;
  logic [DSW-1:0]        data_s;
  logic                  prog_bus_oe;
  logic                  data_bus_en;
  logic                  prog_rd;
  logic                  prog_wr;
  logic                  data_rd;
  logic                  data_wr;

  // reset asserts at once, releases through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[SYNC_DEPTH-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[SYNC_DEPTH-1];

  // pins are synchronised together so read data lines up with ack;
  // costs two cycles of acknowledge latency
  dxm_sync #(.W(PSW)) u_prog_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .rst_val ('0),
    .d       ({prog_ack, !prog_float_req_n, prog_data_i}),
    .q       (prog_s)
  );

  dxm_sync #(.W(DSW)) u_data_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .rst_val ('0),
    .d       ({data_ack, !data_float_req_n, data_bus_i}),
    .q       (data_s)
  );

  dxm_port_engine #(
    .AW  (PROG_AW),
    .DW  (PROG_DW),
    .NB  (PROG_NB),
    .NSH (PROG_NSH)
  ) u_prog (
    .clock      (clock),
    .rst_n      (rst_n),
    .req_valid  (prog_req_valid),
    .req_ready  (prog_req_ready),
    .req_write  (prog_req_write),
    .req_narrow (prog_req_narrow),
    .req_addr   (prog_req_addr),
    .req_wdata  (prog_req_wdata),
    .rsp_valid  (prog_rsp_valid),
    .rsp_rdata  (prog_rsp_rdata),
    .busy       (prog_busy),
    .bank_start (prog_cfg.bank_start),
    .bank_waits (prog_cfg.bank_waits),
    .page_shift (prog_cfg.page_shift),
    .addr_o     (prog_addr),
    .data_o     (prog_data_o),
    .data_oe    (prog_data_oe),
    .data_s     (prog_s[PROG_DW-1:0]),
    .bank_sel_n (prog_bank_sel_n),
    .rd_strobe  (prog_rd),
    .wr_strobe  (prog_wr),
    .bus_oe     (prog_bus_oe),
    .page_cross (prog_page_cross),
    .ack_s      (prog_s[PSW-1]),
    .float_s    (prog_s[PSW-2])
  );

  dxm_port_engine #(
    .AW  (DATA_AW),
    .DW  (DATA_DW),
    .NB  (DATA_NB),
    .NSH (DATA_NSH)
  ) u_data (
    .clock      (clock),
    .rst_n      (rst_n),
    .req_valid  (data_req_valid),
    .req_ready  (data_req_ready),
    .req_write  (data_req_write),
    .req_narrow (data_req_narrow),
    .req_addr   (data_req_addr),
    .req_wdata  (data_req_wdata),
    .rsp_valid  (data_rsp_valid),
    .rsp_rdata  (data_rsp_rdata),
    .busy       (data_busy),
    .bank_start (data_cfg.bank_start),
    .bank_waits (data_cfg.bank_waits),
    .page_shift (data_cfg.page_shift),
    .addr_o     (data_addr),
    .data_o     (data_bus_o),
    .data_oe    (data_bus_oe),
    .data_s     (data_s[DATA_DW-1:0]),
    .bank_sel_n (data_bank_sel_n),
    .rd_strobe  (data_rd),
    .wr_strobe  (data_wr),
    .bus_oe     (data_bus_en),
    .page_cross (data_page_cross),
    .ack_s      (data_s[DSW-1]),
    .float_s    (data_s[DSW-2])
  );

  // strobes leave the chip active low
  assign prog_rd_strobe_n = !prog_rd;
  assign prog_wr_strobe_n = !prog_wr;
  assign data_rd_strobe_n = !data_rd;
  assign data_wr_strobe_n = !data_wr;

  // the float request takes address, selects and strobes together
  assign prog_addr_oe     = prog_bus_oe;
  assign prog_bank_sel_oe = prog_bus_oe;
  assign prog_strobe_oe   = prog_bus_oe;
  assign data_addr_oe     = data_bus_en;
  assign data_bank_sel_oe = data_bus_en;
  assign data_strobe_oe   = data_bus_en;

endmodule

`default_nettype wire

// file: hw/dxm_pkg.sv
// shared constants and carrier types for the dual external memory port
// assumes one core clock; no software-visible registers exist
package dxm_pkg;

  // program memory port geometry
  localparam int PROG_AW   = 24;
  localparam int PROG_DW   = 48;
  localparam int PROG_NB   = 2;
  localparam int PROG_NSH  = 16;
  // data memory port geometry
  localparam int DATA_AW   = 32;
  localparam int DATA_DW   = 40;
  localparam int DATA_NB   = 4;
  localparam int DATA_NSH  = 8;
  // narrow values are 32 bits wide on both ports
  localparam int NARROW_W  = 32;
  // per-bank wait states count 0 to 7
  localparam int WAIT_W    = 3;
  // page shift fields cover every address bit position
  localparam int SHIFT_W   = 6;
  // two flip-flops in the internal reset release chain
  localparam int SYNC_DEPTH = 2;

  typedef enum logic [1:0] {
    DXM_IDLE = 2'b00,
    DXM_ACC  = 2'b01,
    DXM_HALT = 2'b10
  } dxm_state_e;

  // static configuration of the program memory port
  typedef struct packed {
    logic [PROG_NB-2:0][PROG_AW-1:0] bank_start;
    logic [PROG_NB-1:0][WAIT_W-1:0]  bank_waits;
    logic [SHIFT_W-1:0]              page_shift;
  } dxm_prog_cfg_s;

  // static configuration of the data memory port
  typedef struct packed {
    logic [DATA_NB-2:0][DATA_AW-1:0] bank_start;
    logic [DATA_NB-1:0][WAIT_W-1:0]  bank_waits;
    logic [SHIFT_W-1:0]              page_shift;
  } dxm_data_cfg_s;

endpackage

// file: hw/dxm_sync.sv
// two-stage synchroniser for a vector of pin inputs
// assumes reset already released synchronously by the caller
`timescale 1ns/100ps
`default_nettype none

module dxm_sync
  import dxm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] rst_val,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

  // rst_val is unused; both stages reset to zero, so inputs that idle high
  // read low for two cycles after release
  logic unused_rv;
  assign unused_rv = ^rst_val;

endmodule

`default_nettype wire

// file: test/dxm_ext_mem_checker.sv
// pin-side assertions for the dual external memory port
// assumes binding onto dxm_ext_mem; sees only its ports
`timescale 1ns/100ps
`default_nettype none

module dxm_ext_mem_checker
  import dxm_pkg::*;
(
  input wire logic               clock,
  input wire logic               resetn,
  input wire logic               prog_rd_strobe_n,
  input wire logic               prog_wr_strobe_n,
  input wire logic               prog_strobe_oe,
  input wire logic               prog_addr_oe,
  input wire logic [PROG_NB-1:0] prog_bank_sel_n,
  input wire logic               prog_rsp_valid,
  input wire logic               prog_ack,
  input wire logic               prog_float_req_n,
  input wire logic               data_rd_strobe_n,
  input wire logic               data_wr_strobe_n,
  input wire logic               data_strobe_oe,
  input wire logic               data_addr_oe,
  input wire logic [DATA_NB-1:0] data_bank_sel_n,
  input wire logic [DATA_AW-1:0] data_addr,
  input wire logic               data_rsp_valid,
  input wire logic               data_ack,
  input wire logic               data_float_req_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_prog_excl;
    !(!prog_rd_strobe_n && !prog_wr_strobe_n);
  endproperty
  a_prog_excl: assert property (p_prog_excl)
    else $error("program strobes overlap");
  property p_data_excl;
    !(!data_rd_strobe_n && !data_wr_strobe_n);
  endproperty
  a_data_excl: assert property (p_data_excl)
    else $error("data strobes overlap");
  // six samples also cover the internal reset and the two sync stages
  property p_prog_float;
    !prog_float_req_n [*6] |-> !prog_addr_oe && !prog_strobe_oe;
  endproperty
  a_prog_float: assert property (p_prog_float)
    else $error("program pins driven while floated");
  property p_data_float;
    !data_float_req_n [*6] |-> !data_addr_oe && !data_strobe_oe;
  endproperty
  a_data_float: assert property (p_data_float)
    else $error("data pins driven while floated");
  property p_prog_ack;
    !prog_ack [*4] |=> !prog_rsp_valid;
  endproperty
  a_prog_ack: assert property (p_prog_ack)
    else $error("program access ended without ack");
  property p_data_ack;
    !data_ack [*4] |=> !data_rsp_valid;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data access ended without ack");
  property p_prog_rd_end;
    $rose(prog_rd_strobe_n) |-> prog_rsp_valid;
  endproperty
  a_prog_rd_end: assert property (p_prog_rd_end)
    else $error("program read strobe dropped early");
  property p_data_wr_end;
    $rose(data_wr_strobe_n) |-> data_rsp_valid;
  endproperty
  a_data_wr_end: assert property (p_data_wr_end)
    else $error("data write strobe dropped early");
  property p_prog_sel;
    (!prog_rd_strobe_n || !prog_wr_strobe_n) |-> $onehot(~prog_bank_sel_n);
  endproperty
  a_prog_sel: assert property (p_prog_sel)
    else $error("program select not one-hot in access");
  property p_data_sel;
    (!data_rd_strobe_n || !data_wr_strobe_n) |-> $onehot(~data_bank_sel_n);
  endproperty
  a_data_sel: assert property (p_data_sel)
    else $error("data select not one-hot in access");
  property p_data_hold;
    !data_rd_strobe_n && !$past(data_rd_strobe_n) |->
      $stable(data_addr) && $stable(data_bank_sel_n);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data address moved in read");
endmodule

bind dxm_ext_mem dxm_ext_mem_checker u_dxm_ext_mem_checker (
  .clock, .resetn, .prog_rd_strobe_n, .prog_wr_strobe_n, .prog_strobe_oe,
  .prog_addr_oe, .prog_bank_sel_n, .prog_rsp_valid, .prog_ack,
  .prog_float_req_n, .data_rd_strobe_n, .data_wr_strobe_n, .data_strobe_oe,
  .data_addr_oe, .data_bank_sel_n, .data_addr, .data_rsp_valid, .data_ack,
  .data_float_req_n
);
`default_nettype wire

// file: test/dxm_mem_model.sv
// behavioural external memory for one port of the dual memory interface
// assumes strobes already pulled high by the bench while floated
`timescale 1ns/100ps
`default_nettype none

module dxm_mem_model #(
  parameter int AW = 24,
  parameter int DW = 48
) (
  input  wire logic          clock,
  input  wire logic [AW-1:0] addr,
  input  wire logic          rd_n,
  input  wire logic          wr_n,
  input  wire logic [DW-1:0] bus,
  input  wire logic [3:0]    lat,
  output logic               ack,
  output logic      [DW-1:0] q
);
  logic [DW-1:0] mem [logic [AW-1:0]];
  int unsigned   cnt;

  initial begin
    ack = 1'h0;
    q   = '0;
    cnt = 0;
  end

  // ack idles low so a stale high never reaches a fresh access
  always @(posedge clock) begin
    if (rd_n && wr_n) begin
      cnt <= 0;
      ack <= 1'h0;
    end else begin
      cnt <= cnt + 1;
      ack <= (cnt >= lat);
      if (!wr_n) mem[addr] = bus;
    end
    // a released bus keeps changing rather than holding its last value
    q <= (!rd_n && mem.exists(addr)) ? mem[addr] : ~q;
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the dual external memory port
// assumes dxm_mem_model on each port and the bound checker
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import dxm_pkg::*;
  logic          clock = 1'h0;
  logic          resetn = 1'h0;
  logic          rv [2] = '{1'h0, 1'h0};
  logic          rw [2] = '{1'h0, 1'h0};
  logic          rn [2] = '{1'h0, 1'h0};
  logic          fl [2] = '{1'h1, 1'h1};
  logic [31:0]   ra [2] = '{32'h0, 32'h0};
  logic [47:0]   rd [2] = '{48'h0, 48'h0};
  logic [3:0]    lat [2] = '{4'h0, 4'h0};
  dxm_prog_cfg_s prog_cfg = '0;
  dxm_data_cfg_s data_cfg = '0;
  logic          prog_req_ready, prog_rsp_valid, prog_addr_oe, prog_data_oe;
  logic          prog_bank_sel_oe, prog_rd_strobe_n, prog_wr_strobe_n;
  logic          prog_strobe_oe, prog_page_cross, prog_ack, prog_busy;
  logic          data_req_ready, data_rsp_valid, data_addr_oe, data_bus_oe;
  logic          data_bank_sel_oe, data_rd_strobe_n, data_wr_strobe_n;
  logic          data_strobe_oe, data_page_cross, data_ack, data_busy;
  logic [47:0]   prog_rsp_rdata, prog_data_o, pq;
  logic [39:0]   data_rsp_rdata, data_bus_o, dq;
  logic [23:0]   prog_addr;
  logic [31:0]   data_addr;
  logic [1:0]    prog_bank_sel_n;
  logic [3:0]    data_bank_sel_n;
  wire  [47:0]   pbus = prog_data_oe ? prog_data_o : pq;
  wire  [39:0]   dbus = data_bus_oe ? data_bus_o : dq;
  logic [47:0]   mem_exp [logic [32:0]];
  logic [31:0]   last_a [2];
  int            first [2] = '{1, 1};
  int            sh;
  int            seed = 32'h1DDB39DF;
  int            num_errors = 0;
  int            total_checks = 0;

  always #50 clock = ~clock;

  dxm_ext_mem u_dxm_ext_mem (
    .clock, .resetn, .prog_req_valid(rv[0]), .prog_req_ready,
    .prog_req_write(rw[0]), .prog_req_narrow(rn[0]),
    .prog_req_addr(ra[0][23:0]), .prog_req_wdata(rd[0]),
    .prog_rsp_valid, .prog_rsp_rdata, .prog_busy, .prog_cfg,
    .data_req_valid(rv[1]), .data_req_ready, .data_req_write(rw[1]),
    .data_req_narrow(rn[1]), .data_req_addr(ra[1]),
    .data_req_wdata(rd[1][39:0]), .data_rsp_valid, .data_rsp_rdata,
    .data_busy, .data_cfg, .prog_addr, .prog_addr_oe,
    .prog_data_i(pbus), .prog_data_o, .prog_data_oe, .prog_bank_sel_n,
    .prog_bank_sel_oe, .prog_rd_strobe_n, .prog_wr_strobe_n,
    .prog_strobe_oe, .prog_page_cross, .prog_ack,
    .prog_float_req_n(fl[0]), .data_addr, .data_addr_oe,
    .data_bus_i(dbus), .data_bus_o, .data_bus_oe, .data_bank_sel_n,
    .data_bank_sel_oe, .data_rd_strobe_n, .data_wr_strobe_n,
    .data_strobe_oe, .data_page_cross, .data_ack,
    .data_float_req_n(fl[1])
  );

  // floated strobes read high at the memories, as with a pull-up
  dxm_mem_model #(.AW(24), .DW(48)) u_pmem (
    .clock, .addr(prog_addr), .bus(pbus), .lat(lat[0]), .ack(prog_ack),
    .q(pq), .rd_n(prog_strobe_oe ? prog_rd_strobe_n : 1'h1),
    .wr_n(prog_strobe_oe ? prog_wr_strobe_n : 1'h1)
  );
  dxm_mem_model #(.AW(32), .DW(40)) u_dmem (
    .clock, .addr(data_addr), .bus(dbus), .lat(lat[1]), .ack(data_ack),
    .q(dq), .rd_n(data_strobe_oe ? data_rd_strobe_n : 1'h1),
    .wr_n(data_strobe_oe ? data_wr_strobe_n : 1'h1)
  );

  task automatic chk(input logic [47:0] got, input logic [47:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one access on port p (0 program, 1 data); flt floats it midway
  task automatic acc(input int p, input bit wr, input bit nar,
                     input logic [31:0] a, input logic [47:0] d,
                     input bit flt);
    logic [47:0] e;
    logic [3:0]  bk;
    logic [3:0]  es;
    int          n;
    int          w;
    logic        pg;
    repeat (3) @(posedge clock);
    bk = 4'h0;
    if (p == 0) bk = 4'(a[23:0] >= prog_cfg.bank_start[0]);
    else for (int i = 0; i < 3; i++) bk += 4'(a >= data_cfg.bank_start[i]);
    es = ~(4'h1 << bk);
    w = p ? data_cfg.bank_waits[bk[1:0]] : prog_cfg.bank_waits[bk[0]];
    pg = (first[p] == 1) || ((a >> sh) != (last_a[p] >> sh));
    last_a[p] = a;
    if (wr) mem_exp[{p[0], a}] = p ?
        (nar ? {8'h00, d[31:0], 8'h00} : {8'h00, d[39:0]}) :
        (nar ? {d[31:0], 16'h0000} : d);
    e = mem_exp[{p[0], a}];
    if (nar) e = p ? 48'(e[39:8]) : 48'(e[47:16]);
    @(posedge clock);
    rv[p] <= 1'h1;
    rw[p] <= wr;
    rn[p] <= nar;
    ra[p] <= a;
    rd[p] <= d;
    n = 0;
    do begin @(negedge clock); n++; end
    while ((p ? data_req_ready : prog_req_ready) !== 1'h1 && n < 20);
    @(posedge clock);
    rv[p] <= 1'h0;
    @(negedge clock);
    if (p == 0) begin
      chk(48'({prog_strobe_oe, prog_rd_strobe_n, prog_wr_strobe_n,
               prog_busy, prog_data_oe}),
          48'({1'h1, wr, !wr, 1'h1, wr}), "prog strobe");
      chk(48'(prog_addr), 48'(a[23:0]), "prog address");
      chk(48'(prog_bank_sel_n), 48'(es[1:0]), "prog select");
      if (first[p] != 2) chk(48'(prog_page_cross), 48'(pg), "prog page");
    end else begin
      chk(48'({data_strobe_oe, data_rd_strobe_n, data_wr_strobe_n,
               data_busy, data_bus_oe}),
          48'({1'h1, wr, !wr, 1'h1, wr}), "data strobe");
      chk(48'(data_addr), 48'(a), "data address");
      chk(48'(data_bank_sel_n), 48'(es), "data select");
      if (first[p] != 2) chk(48'(data_page_cross), 48'(pg), "data page");
    end
    first[p] = 0;
    if (flt) begin
      @(posedge clock);
      fl[p] <= 1'h0;
      n = 0;
      // long enough for the pin, the reset lag and both sync stages
      repeat (7) begin
        @(negedge clock);
        n += int'((p ? data_rsp_valid : prog_rsp_valid) === 1'h1);
      end
      chk(48'({p ? {data_addr_oe, data_strobe_oe, data_bank_sel_oe}
                 : {prog_addr_oe, prog_strobe_oe, prog_bank_sel_oe},
               n != 0}),
          48'h0, "float");
      @(posedge clock);
      fl[p] <= 1'h1;
    end
    n = 0;
    do begin @(negedge clock); n++; end
    while ((p ? data_rsp_valid : prog_rsp_valid) !== 1'h1 && n < 80);
    chk(48'({(p ? data_rsp_valid : prog_rsp_valid) === 1'h1, n > w,
             p ? data_busy : prog_busy}),
        48'h6, "completion");
    if (!wr) chk(p ? 48'(data_rsp_rdata) : prog_rsp_rdata, e, "read data");
  endtask

  initial begin
    logic [31:0] a;
    logic [47:0] d;
    repeat (12) @(posedge clock);
    resetn <= 1'h1;
    repeat (6) @(posedge clock);
    for (int ps = 0; ps < 2; ps++) begin
      @(posedge clock);
      sh = ps ? 6 : 4;
      if (ps == 1) first = '{2, 2};
      lat[0] <= 4'($random(seed) & 3);
      lat[1] <= 4'($random(seed) & 3);
      prog_cfg.bank_start[0] <= 24'h000080;
      prog_cfg.bank_waits <= ps ? {3'h5, 3'h6} : {3'h7, 3'h0};
      prog_cfg.page_shift <= 6'(sh);
      data_cfg.bank_start <= {32'h000000C0, 32'h00000080, 32'h00000040};
      data_cfg.bank_waits <= ps ? {3'h0, 3'h7, 3'h1, 3'h3}
                                : {3'h4, 3'h3, 3'h2, 3'h1};
      data_cfg.page_shift <= 6'(sh);
      for (int i = 0; i < 16; i++) begin
        a = 32'($random(seed)) & 32'h000000FF;
        d = 48'({$random(seed), $random(seed)});
        acc(i % 2, 1'h1, 1'($random(seed)), a, d, 1'h0);
        acc(i % 2, 1'h0, 1'($random(seed)), a, d, 1'h0);
      end
      $display("test pass with page shift %0d done", sh);
    end
    lat[0] <= 4'h6;
    lat[1] <= 4'h6;
    for (int p = 0; p < 2; p++) begin
      d = 48'({$random(seed), $random(seed)});
      acc(p, 1'h1, 1'h0, 32'h000000A5, d, 1'h0);
      acc(p, 1'h0, 1'h0, 32'h000000A5, d, 1'h1);
      $display("test float on port %0d done", p);
    end
    close_out();
  end

  // about 70 accesses of at most 60 cycles each, with ample margin
  initial begin
    #3000000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
